// ---- verilog/led_engine_params.svh ----
`ifndef LED_ENGINE_PARAMS_SVH
`define LED_ENGINE_PARAMS_SVH

// Register offsets on the serial register port.
`define OFS_IDLE        8'h10
`define OFS_OFF_DELAY   8'h11
`define OFS_E1_ON       8'h12
`define OFS_E1_FADE     8'h13
`define OFS_E2_ON       8'h14
`define OFS_E2_FADE     8'h15
`define OFS_PWR_IDLE    8'h16
`define OFS_PWR_ON      8'h17
`define OFS_PWR_OFF     8'h18
`define OFS_PWR_FADE    8'h19
`define OFS_PULSE_W     8'h1A
`define OFS_PWR_MODE    8'h1B
`define OFS_MAP1        8'h0C
`define OFS_MAP2        8'h0D

// Mode register field positions.
`define BIT_TRANS_SEL   7
`define BIT_PEAK_SEL    6
`define BIT_BREATH_HI   5
`define BIT_WAVE_SEL    4
`define BIT_PB_EN       1
`define BIT_INVERT      0
`define MODE_RSVD_MASK  8'h0C

// Levels and reset values.
`define FULL_SCALE      8'hFF
`define RESET_VALUE     8'h00
`define PWM_PERIOD      8'hFF

// Timing: figures in their own unit, cycles derived at 50 MHz.
`define CLK_MHZ         50
`define STEP_E_US       500
`define STEP_P_US       250
`define UNIT_MS         1
`define DELAY_MS        256
`define CYC_500US       (`STEP_E_US * `CLK_MHZ)
`define CYC_250US       (`STEP_P_US * `CLK_MHZ)
`define CYC_1MS         (`UNIT_MS * 1000 * `CLK_MHZ)
`define MS_PER_DELAY    `DELAY_MS

`endif

// ---- verilog/led_engine_pkg.sv ----
`default_nettype none
package led_engine_pkg;
    // One register-port write or read request.
    typedef struct packed {
        logic       wr;
        logic       rd;
        logic [7:0] addr;
        logic [7:0] wdata;
    } reg_req_t;

    // Power-button engine sequence states.
    typedef enum logic [2:0] {
        PB_IDLE,
        PB_TOUCH,
        PB_PEAK,
        PB_BREATH,
        PB_BREATH_TIMED
    } pb_state_t;
endpackage
`default_nettype wire

// ---- verilog/led_engine_fade_power_button.sv ----
`timescale 1ns/1ps
`default_nettype none
`include "led_engine_params.svh"

module led_engine_fade_power_button
(
    // Clock and reset.
    input  wire logic                      clk_sys,
    input  wire logic                      nrst,
    // Register port.
    input  wire led_engine_pkg::reg_req_t  reg_req,
    output logic [7:0]                     reg_rdata,
    // Sensing and power state.
    input  wire logic [7:0]                touch_in,
    input  wire logic [7:0]                prox_in,
    input  wire logic                      system_power_state,
    input  wire logic                      power_pin_selected,
    input  wire logic                      pwm_tick,
    // Outputs.
    output logic [7:0]                     led_pwm_out,
    output logic                           power_on_pulse_out,
    output logic [7:0]                     level_one_out,
    output logic [7:0]                     level_two_out,
    output logic [7:0]                     level_pwr_out
);

    // ********************************************************************
    // Register file
    // ********************************************************************

    logic [7:0] idle_reg;      // Shared idle level.
    logic [7:0] delay_reg;     // Off delays, engine one high nibble.
    logic [7:0] on1_reg;       // Engine one on level.
    logic [7:0] fade1_reg;     // Engine one fade timing.
    logic [7:0] on2_reg;       // Engine two on level.
    logic [7:0] fade2_reg;     // Engine two fade timing.
    logic [7:0] pidle_reg;     // Power LED idle level.
    logic [7:0] pon_reg;       // Power LED on level.
    logic [7:0] poff_reg;      // Power LED off level.
    logic [7:0] pfade_reg;     // Power LED fade timing.
    logic [7:0] pulse_reg;     // Pulse duration.
    logic [7:0] mode_reg;      // Power LED mode control.
    logic [7:0] map1_reg;      // Channels on engine one.
    logic [7:0] map2_reg;      // Channels on engine two.
    logic       pstate_reg;    // Software-written power state.

    // Register writes; reserved mode bits are forced clear so a careless
    // write cannot enable undefined behaviour.
    always_ff @(posedge clk_sys or negedge nrst)
    begin
        if (!nrst)
        begin
            idle_reg   <= `RESET_VALUE;
            delay_reg  <= `RESET_VALUE;
            on1_reg    <= `RESET_VALUE;
            fade1_reg  <= `RESET_VALUE;
            on2_reg    <= `RESET_VALUE;
            fade2_reg  <= `RESET_VALUE;
            pidle_reg  <= `RESET_VALUE;
            pon_reg    <= `RESET_VALUE;
            poff_reg   <= `RESET_VALUE;
            pfade_reg  <= `RESET_VALUE;
            pulse_reg  <= `RESET_VALUE;
            mode_reg   <= `RESET_VALUE;
            map1_reg   <= `RESET_VALUE;
            map2_reg   <= `RESET_VALUE;
            pstate_reg <= 1'b0;
        end
        else if (reg_req.wr)
        begin
            case (reg_req.addr)
                `OFS_IDLE:      idle_reg  <= reg_req.wdata;
                `OFS_OFF_DELAY: delay_reg <= reg_req.wdata;
                `OFS_E1_ON:     on1_reg   <= reg_req.wdata;
                `OFS_E1_FADE:   fade1_reg <= reg_req.wdata;
                `OFS_E2_ON:     on2_reg   <= reg_req.wdata;
                `OFS_E2_FADE:   fade2_reg <= reg_req.wdata;
                `OFS_PWR_IDLE:  pidle_reg <= reg_req.wdata;
                `OFS_PWR_ON:    pon_reg   <= reg_req.wdata;
                `OFS_PWR_OFF:   poff_reg  <= reg_req.wdata;
                `OFS_PWR_FADE:  pfade_reg <= reg_req.wdata;
                `OFS_PULSE_W:   pulse_reg <= reg_req.wdata;
                `OFS_PWR_MODE:  mode_reg  <= reg_req.wdata & ~`MODE_RSVD_MASK;
                `OFS_MAP1:      map1_reg  <= reg_req.wdata;
                `OFS_MAP2:      map2_reg  <= reg_req.wdata;
                8'h07:          pstate_reg <= reg_req.wdata[4];
                default:        idle_reg  <= idle_reg;
            endcase
        end
    end

    // Power state comes from the pin when so configured.
    logic pstate;
    assign pstate = power_pin_selected ? system_power_state : pstate_reg;

    // Engine levels, copied to the level outputs; not readable on the register port.
    logic [7:0] lvl1_reg;
    logic [7:0] lvl2_reg;
    logic [7:0] lvlp_reg;

    // Registered readback; unmapped addresses read zero.
    always_ff @(posedge clk_sys or negedge nrst)
    begin
        if (!nrst)
            reg_rdata <= `RESET_VALUE;
        else if (reg_req.rd)
        begin
            case (reg_req.addr)
                `OFS_IDLE:      reg_rdata <= idle_reg;
                `OFS_OFF_DELAY: reg_rdata <= delay_reg;
                `OFS_E1_ON:     reg_rdata <= on1_reg;
                `OFS_E1_FADE:   reg_rdata <= fade1_reg;
                `OFS_E2_ON:     reg_rdata <= on2_reg;
                `OFS_E2_FADE:   reg_rdata <= fade2_reg;
                `OFS_PWR_IDLE:  reg_rdata <= pidle_reg;
                `OFS_PWR_ON:    reg_rdata <= pon_reg;
                `OFS_PWR_OFF:   reg_rdata <= poff_reg;
                `OFS_PWR_FADE:  reg_rdata <= pfade_reg;
                `OFS_PULSE_W:   reg_rdata <= pulse_reg;
                `OFS_PWR_MODE:  reg_rdata <= mode_reg;
                `OFS_MAP1:      reg_rdata <= map1_reg;
                `OFS_MAP2:      reg_rdata <= map2_reg;
                8'h07:          reg_rdata <= {3'h0, pstate, 4'h0};
                default:        reg_rdata <= `RESET_VALUE;
            endcase
        end
    end

    // ********************************************************************
    // Timebase
    // ********************************************************************

    // Shared 250 us, 500 us and 1 ms enable pulses from one divider.
    logic [15:0] div_reg;
    logic        tick_250;
    logic        tick_500;
    logic        tick_1ms;
    logic [1:0]  sub_reg;

    always_ff @(posedge clk_sys or negedge nrst)
    begin
        if (!nrst)
        begin
            div_reg <= 16'h0000;
            sub_reg <= 2'h0;
        end
        else if (div_reg == 16'(`CYC_250US - 1))
        begin
            div_reg <= 16'h0000;
            sub_reg <= sub_reg + 2'h1;
        end
        else
            div_reg <= div_reg + 16'h0001;
    end

    assign tick_250 = (div_reg == 16'(`CYC_250US - 1));
    assign tick_500 = tick_250 && sub_reg[0];
    assign tick_1ms = tick_250 && (sub_reg == 2'h3);

    // ********************************************************************
    // General engines
    // ********************************************************************

    // Target for a general engine: touch wins over proximity over idle.
    function automatic logic [7:0] gen_target(input logic t, input logic p,
                                              input logic [7:0] on_lvl,
                                              input logic [7:0] idl);
        logic [7:0] inv_on;
        inv_on = mode_reg[`BIT_INVERT] ? (`FULL_SCALE - on_lvl) : on_lvl;
        if (t)
            gen_target = inv_on;
        else if (p)
            gen_target = on_lvl;
        else
            gen_target = idl;
    endfunction

    // One unit toward target; no change when equal.
    function automatic logic [7:0] step_to(input logic [7:0] cur, input logic [7:0] tgt);
        if (cur < tgt)
            step_to = cur + 8'h01;
        else if (cur > tgt)
            step_to = cur - 8'h01;
        else
            step_to = cur;
    endfunction

    logic [7:0] t1_in;
    logic [7:0] t2_in;
    logic       act1;
    logic       act2;
    logic       prx1;
    logic       prx2;
    assign t1_in = touch_in & map1_reg;
    assign t2_in = touch_in & map2_reg;
    assign act1  = |t1_in;
    assign act2  = |t2_in;
    assign prx1  = |prox_in;
    assign prx2  = |prox_in;

    logic [7:0] tgt1;
    logic [7:0] tgt2;
    assign tgt1 = gen_target(act1, prx1, on1_reg, idle_reg);
    assign tgt2 = gen_target(act2, prx2, on2_reg, idle_reg);

    // Per-engine views; the counters live in each engine's own scope below so that
    // every counter has exactly one driving process.
    logic [7:0]  tgt_g   [2];
    logic [3:0]  nib_d   [2];
    logic [7:0]  fade_g  [2];
    logic        act_g   [2];

    assign tgt_g[0]  = tgt1;
    assign tgt_g[1]  = tgt2;
    assign nib_d[0]  = delay_reg[7:4];
    assign nib_d[1]  = delay_reg[3:0];
    assign fade_g[0] = fade1_reg;
    assign fade_g[1] = fade2_reg;
    assign act_g[0]  = act1 | prx1;
    assign act_g[1]  = act2 | prx2;

    logic [7:0] lvl_g [2];
    assign lvl_g[0] = lvl1_reg;
    assign lvl_g[1] = lvl2_reg;

    logic [7:0] lvl_next [2];

    for (genvar g = 0; g < 2; g++)
    begin : gen_eng
        // Rising toward target uses fade-in nibble, falling the fade-out.
        logic        rising;
        logic [11:0] dly_reg;   // Off-delay remaining in ms.
        logic [3:0]  stp_reg;   // Steps of 500 us left in current unit.
        logic        was_act;   // Last cycle had touch or proximity.
        assign rising = tgt_g[g] > lvl_g[g];

        always_ff @(posedge clk_sys or negedge nrst)
        begin
            if (!nrst)
            begin
                dly_reg <= 12'h000;
                stp_reg <= 4'h0;
                was_act <= 1'b0;
            end
            else
            begin
                was_act <= act_g[g];
                if (was_act && !act_g[g])
                    dly_reg <= 12'(nib_d[g]) * 12'(`MS_PER_DELAY);
                else if (act_g[g])
                    dly_reg <= 12'h000;
                else if (tick_1ms && dly_reg != 12'h000)
                    dly_reg <= dly_reg - 12'h001;
                if (tick_500)
                begin
                    if (stp_reg == 4'h0)
                        stp_reg <= rising ? fade_g[g][7:4] : fade_g[g][3:0];
                    else
                        stp_reg <= stp_reg - 4'h1;
                end
            end
        end

        // A level moves one unit per step interval, after any off delay.
        assign lvl_next[g] = (tick_500 && stp_reg == 4'h0 && dly_reg == 12'h000)
                             ? step_to(lvl_g[g], tgt_g[g]) : lvl_g[g];
    end

    always_ff @(posedge clk_sys or negedge nrst)
    begin
        if (!nrst)
        begin
            lvl1_reg <= `RESET_VALUE;
            lvl2_reg <= `RESET_VALUE;
        end
        else
        begin
            lvl1_reg <= lvl_next[0];
            lvl2_reg <= lvl_next[1];
        end
    end

    // ********************************************************************
    // Power-button engine
    // ********************************************************************

    led_engine_pkg::pb_state_t pb_reg;
    logic [7:0] ptgt;          // Current power LED target.
    logic [7:0] pstep_reg;     // 250 us ticks left in step.
    logic [8:0] ptime_reg;     // Ms left for timed phases.
    logic       bdir_reg;      // Breathing direction, high when rising.
    logic       pb_touch;
    logic       pb_touch_d;
    logic [7:0] peak;
    logic [7:0] bhi;
    logic       pstate_d;
    logic       seq_pwr_reg;   // Peak phase was started by a power-state change.

    assign pb_touch = touch_in[7] && mode_reg[`BIT_PB_EN];
    assign peak = mode_reg[`BIT_PEAK_SEL] ? `FULL_SCALE : pon_reg;
    assign bhi  = mode_reg[`BIT_BREATH_HI] ? pon_reg : pidle_reg;

    // Sequencer: a touch on the power button starts the timed sequence.
    always_ff @(posedge clk_sys or negedge nrst)
    begin
        if (!nrst)
        begin
            pb_reg     <= led_engine_pkg::PB_IDLE;
            ptime_reg  <= 9'h000;
            bdir_reg   <= 1'b0;
            pb_touch_d <= 1'b0;
            pstate_d   <= 1'b0;
            seq_pwr_reg <= 1'b0;
        end
        else
        begin
            pb_touch_d <= pb_touch;
            pstate_d   <= pstate;
            if (tick_1ms && ptime_reg != 9'h000)
                ptime_reg <= ptime_reg - 9'h001;
            if (lvlp_reg == ptgt)
                bdir_reg <= ~bdir_reg;
            case (pb_reg)
                led_engine_pkg::PB_IDLE:
                begin
                    if (pb_touch && !pb_touch_d)
                    begin
                        ptime_reg <= {1'b0, pulse_reg} + 9'h001;
                        seq_pwr_reg <= 1'b0;
                        if (mode_reg[`BIT_WAVE_SEL])
                            pb_reg <= led_engine_pkg::PB_PEAK;
                        else
                            pb_reg <= led_engine_pkg::PB_BREATH_TIMED;
                    end
                    else if (pstate_d && !pstate)
                    begin
                        ptime_reg <= {1'b0, pulse_reg} + 9'h001;
                        seq_pwr_reg <= 1'b1;
                        if (mode_reg[`BIT_TRANS_SEL] && pstate_d)
                            pb_reg <= led_engine_pkg::PB_PEAK;
                        else
                            pb_reg <= led_engine_pkg::PB_BREATH;
                    end
                    else if (touch_in[7] && !mode_reg[`BIT_PB_EN])
                        pb_reg <= led_engine_pkg::PB_TOUCH;
                end
                led_engine_pkg::PB_TOUCH:
                    if (!touch_in[7])
                        pb_reg <= led_engine_pkg::PB_IDLE;
                led_engine_pkg::PB_PEAK:
                    if (ptime_reg == 9'h000)
                        // A power-state peak goes on to breathe; a button peak
                        // settles back to idle whatever the waveform bit says.
                        pb_reg <= seq_pwr_reg ? led_engine_pkg::PB_BREATH
                                              : led_engine_pkg::PB_IDLE;
                led_engine_pkg::PB_BREATH:
                    if (pstate)
                        pb_reg <= led_engine_pkg::PB_IDLE;
                led_engine_pkg::PB_BREATH_TIMED:
                    if (ptime_reg == 9'h000)
                        pb_reg <= led_engine_pkg::PB_IDLE;
                default:
                    pb_reg <= led_engine_pkg::PB_IDLE;
            endcase
        end
    end

    // Target level by state.
    always_comb
    begin
        case (pb_reg)
            led_engine_pkg::PB_TOUCH:        ptgt = mode_reg[`BIT_INVERT] ? (`FULL_SCALE - pon_reg) : pon_reg;
            led_engine_pkg::PB_PEAK:         ptgt = peak;
            led_engine_pkg::PB_BREATH,
            led_engine_pkg::PB_BREATH_TIMED: ptgt = bdir_reg ? bhi : poff_reg;
            default:                         ptgt = pidle_reg;
        endcase
    end

    // Power LED stepping at (n+1) * 250 us per unit.
    always_ff @(posedge clk_sys or negedge nrst)
    begin
        if (!nrst)
        begin
            pstep_reg <= 8'h00;
            lvlp_reg  <= `RESET_VALUE;
        end
        else if (tick_250)
        begin
            if (pstep_reg == 8'h00)
            begin
                pstep_reg <= pfade_reg;
                lvlp_reg  <= step_to(lvlp_reg, ptgt);
            end
            else
                pstep_reg <= pstep_reg - 8'h01;
        end
    end

    // Power-on pulse lasts (n+1) ms from the button press.
    logic [8:0] pulse_cnt;
    always_ff @(posedge clk_sys or negedge nrst)
    begin
        if (!nrst)
        begin
            pulse_cnt          <= 9'h000;
            power_on_pulse_out <= 1'b0;
        end
        else
        begin
            if (pb_touch && !pb_touch_d)
                pulse_cnt <= {1'b0, pulse_reg} + 9'h001;
            else if (tick_1ms && pulse_cnt != 9'h000)
                pulse_cnt <= pulse_cnt - 9'h001;
            power_on_pulse_out <= (pulse_cnt != 9'h000);
        end
    end

    // ********************************************************************
    // PWM output
    // ********************************************************************

    // Duty comparison against a 255-clock LED period.
    logic [7:0] pwm_cnt;
    always_ff @(posedge clk_sys or negedge nrst)
    begin
        if (!nrst)
        begin
            pwm_cnt     <= 8'h00;
            led_pwm_out <= 8'h00;
        end
        else if (pwm_tick)
        begin
            pwm_cnt <= (pwm_cnt == `PWM_PERIOD - 8'h01) ? 8'h00 : pwm_cnt + 8'h01;
            for (int c = 0; c < 8; c++)
                led_pwm_out[c] <= (c == 7 && mode_reg[`BIT_PB_EN]) ? (pwm_cnt < lvlp_reg)
                                : ((map1_reg[c] && pwm_cnt < lvl1_reg) ||
                                   (map2_reg[c] && pwm_cnt < lvl2_reg));
        end
    end

    always_ff @(posedge clk_sys or negedge nrst)
    begin
        if (!nrst)
        begin
            level_one_out <= 8'h00;
            level_two_out <= 8'h00;
            level_pwr_out <= 8'h00;
        end
        else
        begin
            level_one_out <= lvl1_reg;
            level_two_out <= lvl2_reg;
            level_pwr_out <= lvlp_reg;
        end
    end

    // ********************************************************************
    // Checks
    // ********************************************************************

    step_one_a: assert property (@(posedge clk_sys) disable iff (!nrst)
        (lvl1_reg != $past(lvl1_reg)) |-> $past(tick_500))
        else $error("level moved off tick");
    step_unit_a: assert property (@(posedge clk_sys) disable iff (!nrst)
        ((lvlp_reg - $past(lvlp_reg)) == 8'h01) || (($past(lvlp_reg) - lvlp_reg) <= 8'h01))
        else $error("step not one");
    pulse_gate_a: assert property (@(posedge clk_sys) disable iff (!nrst)
        $rose(pulse_cnt != 9'h000) |-> $past(mode_reg[`BIT_PB_EN]))
        else $error("pulse without enable");
    rsvd_zero_a: assert property (@(posedge clk_sys) disable iff (!nrst)
        (mode_reg & `MODE_RSVD_MASK) == 8'h00)
        else $error("reserved set");
    delay_load_a: assert property (@(posedge clk_sys) disable iff (!nrst)
        (gen_eng[0].was_act && !act_g[0])
        |=> gen_eng[0].dly_reg == 12'(delay_reg[7:4]) * 12'(`MS_PER_DELAY))
        else $error("delay load");
    restart_a: assert property (@(posedge clk_sys) disable iff (!nrst)
        act_g[0] |=> gen_eng[0].dly_reg == 12'h000)
        else $error("no restart");
    pulse_out_a: assert property (@(posedge clk_sys) disable iff (!nrst)
        (pulse_cnt != 9'h000) |=> power_on_pulse_out)
        else $error("pulse out");
    peak_sel_a: assert property (@(posedge clk_sys) disable iff (!nrst)
        (pb_reg == led_engine_pkg::PB_PEAK && mode_reg[`BIT_PEAK_SEL]) |-> ptgt == `FULL_SCALE)
        else $error("peak");
    cv_pulse_c: cover property (@(posedge clk_sys) disable iff (!nrst) $rose(power_on_pulse_out));
    cv_breath_c: cover property (@(posedge clk_sys) disable iff (!nrst) pb_reg == led_engine_pkg::PB_BREATH);
    cv_fade_c: cover property (@(posedge clk_sys) disable iff (!nrst) lvl1_reg == on1_reg && act1);

endmodule

`default_nettype wire

// ---- dv/power_partner.sv ----
`timescale 1ns/1ps
`default_nettype none
// ****************
// LED clock source and power controller
// ****************
module power_partner
(
    // Clock and reset.
    input  wire logic clk_sys,
    input  wire logic nrst,
    // Power state wanted by the bench.
    input  wire logic state_req,
    // Towards the block.
    output logic      pwm_tick,
    output logic      system_power_state
);
    logic [1:0] div_reg; // Divider for the LED clock enable.
    // A tick every fourth cycle keeps the duty path moving without slowing the run.
    always_ff @(posedge clk_sys or negedge nrst)
    begin
        if (!nrst)
            div_reg <= 2'h0;
        else
            div_reg <= div_reg + 2'h1;
    end
    assign pwm_tick = (div_reg == 2'h3);
    // The controller holds the pin steady; it changes only when asked.
    always_ff @(posedge clk_sys or negedge nrst)
    begin
        if (!nrst)
            system_power_state <= 1'b0;
        else
            system_power_state <= state_req;
    end
endmodule
`default_nettype wire

// ---- dv/tb_top.sv ----
`timescale 1ns/1ps
`default_nettype none
// ****************
// Self-checking bench
// ****************
module tb_top;
    localparam int STEP_CYC = 500 * 50; // One engine step at n = 0.
    logic                     clk_sys;   // System clock.
    logic                     nrst;      // Active-low reset.
    led_engine_pkg::reg_req_t reg_req;   // Register request.
    logic [7:0]               reg_rdata; // Read data.
    logic [7:0]               touch_in;  // Touch per channel.
    logic                     state_req; // Wanted power state.
    logic                     pwm_tick;  // LED clock enable.
    logic                     pwr_state; // Power state pin.
    logic [7:0]               lvl1;      // Engine one level.
    logic [7:0]               lvl2;      // Engine two level.
    logic [7:0]               lvl_pwr;   // Power LED level.
    logic [7:0]               pwm_out;   // Channel drive.
    logic                     pwr_pulse; // Power-on pulse.
    int                       error_cnt; // Mismatches.
    int                       tests_run; // Comparisons.
    led_engine_fade_power_button i_dut (.clk_sys(clk_sys), .nrst(nrst), .reg_req(reg_req),
        .reg_rdata(reg_rdata), .touch_in(touch_in), .prox_in(8'h00),
        .system_power_state(pwr_state), .power_pin_selected(1'b1), .pwm_tick(pwm_tick),
        .led_pwm_out(pwm_out), .power_on_pulse_out(pwr_pulse), .level_one_out(lvl1),
        .level_two_out(lvl2), .level_pwr_out(lvl_pwr));
    power_partner i_far (.clk_sys(clk_sys), .nrst(nrst), .state_req(state_req),
        .pwm_tick(pwm_tick), .system_power_state(pwr_state));
    // Free-running clock.
    initial
    begin
        clk_sys = 1'b0;
        forever #10 clk_sys = ~clk_sys;
    end
    task automatic give_verdict();
        $display("error_cnt=%0d tests_run=%0d", error_cnt, tests_run);
        if (error_cnt == 0 && tests_run > 0)
            $display("STATUS OK");
        else
            $display("STATUS NOT OK");
        $finish;
    endtask
    task automatic check(input logic [7:0] got, input logic [7:0] exp);
        tests_run++;
        if (got !== exp)
        begin
            error_cnt++;
            $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    // A write is a one-cycle strobe; the gap edge keeps drivers single.
    task automatic reg_wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge clk_sys);
        reg_req <= '{1'b1, 1'b0, a, d};
        @(posedge clk_sys);
        reg_req <= '0;
    endtask
    // Read data stands from the edge after the strobe until the next read.
    task automatic reg_rd(input logic [7:0] a, output logic [7:0] d);
        @(posedge clk_sys);
        reg_req <= '{1'b0, 1'b1, a, 8'h00};
        @(posedge clk_sys);
        reg_req <= '0;
        @(posedge clk_sys);
        d = reg_rdata;
    endtask
    // Wait for engine one to reach a level; the cycle count comes back.
    task automatic wait_lvl(input logic [7:0] lvl, output int n);
        n = 0;
        while (lvl1 !== lvl && n < 2 * STEP_CYC)
        begin
            @(posedge clk_sys);
            n++;
        end
        check(8'(n >= STEP_CYC / 2 && n < 2 * STEP_CYC), 8'h01);
        if (n >= 2 * STEP_CYC)
            give_verdict();
    endtask
    task automatic t_regs();
        logic [7:0] d;
        for (logic [8:0] a = 9'h010; a < 9'h01C; a++)
            reg_wr(a[7:0], (a == 9'h01B) ? 8'h53 : a[7:0] * 8'h0D);
        for (logic [8:0] a = 9'h010; a < 9'h01C; a++)
        begin
            reg_rd(a[7:0], d);
            check(d, (a == 9'h01B) ? 8'h53 : a[7:0] * 8'h0D);
        end
        reg_rd(8'h40, d);
        check(d, 8'h00);
    endtask
    // One step up on touch, then one step down after release with no delay.
    task automatic t_fade();
        int n;
        int k;
        logic [7:0] m;
        reg_wr(8'h1B, 8'h00);
        reg_wr(8'h10, 8'h00);
        reg_wr(8'h11, 8'h00);
        reg_wr(8'h12, 8'h01);
        reg_wr(8'h13, 8'h00);
        reg_wr(8'h0C, 8'h01);
        reg_wr(8'h0D, 8'h00);
        @(posedge clk_sys);
        touch_in <= 8'h01;
        wait_lvl(8'h01, n);
        // Level 1 gives one LED clock of drive per 255-clock period, on channel zero only.
        k = 0;
        m = 8'h00;
        repeat (1100)
        begin
            @(posedge clk_sys);
            if (pwm_out[0])
                k++;
            m = m | {1'b0, pwm_out[7:1]};
        end
        check(8'(k >= 4 && k <= 8), 8'h01);
        check(m, 8'h00);
        check(lvl_pwr, 8'h01);
        check(lvl1, 8'h01);
        check(lvl2, 8'h00);
        touch_in <= 8'h00;
        wait_lvl(8'h00, n);
    endtask
    // Power state readback, then the power-on pulse with the button off and on.
    task automatic t_pulse();
        logic [7:0] d;
        state_req <= 1'b1;
        repeat (3) @(posedge clk_sys);
        reg_rd(8'h07, d);
        check(d, 8'h10);
        state_req <= 1'b0;
        repeat (3) @(posedge clk_sys);
        reg_rd(8'h07, d);
        check(d, 8'h00);
        reg_wr(8'h1A, 8'h03);
        touch_in <= 8'h80;
        repeat (3) @(posedge clk_sys);
        check({7'h00, pwr_pulse}, 8'h00);
        touch_in <= 8'h00;
        reg_wr(8'h1B, 8'h02);
        touch_in <= 8'h80;
        repeat (3) @(posedge clk_sys);
        check({7'h00, pwr_pulse}, 8'h01);
        touch_in <= 8'h00;
    endtask
    initial
    begin
        nrst = 1'b0;
        reg_req = '0;
        touch_in = 8'h00;
        state_req = 1'b0;
        error_cnt = 0;
        tests_run = 0;
        repeat (4) @(posedge clk_sys);
        nrst <= 1'b1;
        t_regs();
        t_fade();
        t_pulse();
        give_verdict();
    end
endmodule
`default_nettype wire
